// [rtl/fprs_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fprs_cfg.svh"
module fprs_sequencer
    import fprs_pkg::*;
#(
    parameter int MS_CYCLES = `FPRS_MS_NS / `FPRS_CLK_NS,
    parameter int STAB_MS = `FPRS_STAB_MS,
    parameter int AUTO_LP_MS = `FPRS_AUTO_LP_MS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Command engine data path and status
    output logic data_rd,
    output logic data_wr,
    output logic [7:0] data_wdata,
    input wire logic [7:0] data_rdata,
    input wire logic [7:0] msr_core,
    input wire logic core_idle,
    // Configure command
    input wire logic cfg_valid,
    input wire logic cfg_fifo_en,
    input wire logic [3:0] cfg_fifo_level_threshold,
    input wire logic [7:0] cfg_precomp_start_track,
    input wire logic cfg_implied_seek,
    input wire logic cfg_poll_en,
    // Mode command
    input wire logic mode_valid,
    input wire logic mode_manual_lp,
    input wire logic mode_auto_lp,
    input wire logic mode_wfifo,
    input wire logic mode_rfifo,
    input wire logic mode_burst,
    // Lock command
    input wire logic lock_valid,
    input wire logic lock_val,
    // Power and reset control
    output logic osc_run,
    output logic sep_run,
    output logic core_clk_en,
    output logic core_rst,
    output logic low_power,
    // Settings
    output logic [7:0] digital_output_reg,
    output logic [1:0] data_rate,
    output logic [2:0] precomp_sel,
    output logic fifo_en,
    output logic [3:0] fifo_level_threshold,
    output logic [7:0] precomp_start_track,
    output logic implied_seek,
    output logic poll_en,
    output logic write_fifo_setting,
    output logic read_fifo_setting,
    output logic burst_setting,
    output logic lock_flag
);
    if (MS_CYCLES < 1 || STAB_MS < 1 || STAB_MS > 65535 ||
        AUTO_LP_MS < 1 || AUTO_LP_MS > 65535) begin : g_chk
        $error("fprs_sequencer: timer parameter out of range");
    end

    localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

    fprs_state_e state;
    fprs_state_e next_state;
    logic [31:0] ms_cnt;
    logic ms_tick;
    logic dsr_lp;
    logic mode_lp;
    logic dsr_rst;
    logic auto_lp_en;
    logic [1:0] ccr_rate;
    logic soft_req;
    logic lp_wr;
    logic manual_lp;
    logic msr_acc;
    logic data_acc;
    logic wake_acc;
    logic leave_down;
    logic [7:0] msr_val;
    logic [7:0] rd_mux;

    fprs_tmr_if init_t ();
    fprs_tmr_if stab_t ();
    fprs_tmr_if auto_t ();

    fprs_timer u_init (.ref_clk(ref_clk), .sys_rst(sys_rst), .t(init_t));
    fprs_timer u_stab (.ref_clk(ref_clk), .sys_rst(sys_rst), .t(stab_t));
    fprs_timer u_auto (.ref_clk(ref_clk), .sys_rst(sys_rst), .t(auto_t));

    // Decode of the host strobes.
    assign lp_wr = reg_wr && reg_addr == `FPRS_A_DSR &&
        reg_wdata[`FPRS_DSR_LP_BIT];
    assign msr_acc = reg_rd && reg_addr == `FPRS_A_MSR;
    assign data_acc = (reg_rd || reg_wr) && reg_addr == `FPRS_A_DATA;
    assign wake_acc = msr_acc || data_acc;
    assign soft_req = !digital_output_reg[`FPRS_DOR_NRST_BIT] || dsr_rst;
    assign manual_lp = dsr_lp || mode_lp || lp_wr;
    assign leave_down = state == st_down && next_state != st_down;

    // The millisecond enable runs free so that wake-up timing works even
    // though the core is halted.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || ms_tick) begin
            ms_cnt <= '0;
        end else begin
            ms_cnt <= ms_cnt + 32'h0000_0001;
        end
    end
    assign ms_tick = ms_cnt == MS_LAST;

    // Initialisation timer: counts reference cycles once reset is released.
    assign init_t.tick = 1'b1;
    // Loading the count and the state change cost two cycles, so the count
    // is shortened by two to keep the ready bound after reset.
    assign init_t.limit = 16'(`FPRS_INIT_CYC - 2);
    assign init_t.stop = soft_req;
    assign init_t.start = state == st_init && !soft_req &&
        !init_t.run && !init_t.done;

    // Oscillator stabilisation timer.
    assign stab_t.tick = ms_tick;
    assign stab_t.limit = 16'(STAB_MS);
    assign stab_t.stop = soft_req;
    assign stab_t.start = state == st_down && next_state == st_wake;

    // Idle timer for automatic low power; core activity (core_idle low) restarts it.
    assign auto_t.tick = ms_tick;
    assign auto_t.limit = 16'(AUTO_LP_MS);
    assign auto_t.stop = !(state == st_run && auto_lp_en && core_idle);
    assign auto_t.start = state == st_run && auto_lp_en && core_idle &&
        !auto_t.run && !auto_t.done;

    always_comb begin
        next_state = state;
        unique case (state)
            st_init: begin
                if (!soft_req && init_t.done) begin
                    next_state = st_run;
                end
            end
            st_run: begin
                if (soft_req) begin
                    next_state = st_init;
                end else if (manual_lp || auto_t.done) begin
                    next_state = st_down;
                end
            end
            st_down: begin
                if (soft_req) begin
                    next_state = st_init;
                end else if (wake_acc) begin
                    next_state = st_wake;
                end
            end
            st_wake: begin
                if (soft_req) begin
                    next_state = st_init;
                end else if (stab_t.done) begin
                    next_state = st_run;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= st_init;
        end else begin
            state <= next_state;
        end
    end

    // Oscillator and separator stop together; the core clock enable follows
    // once the oscillator is stable on a wake-up, but at once on a software reset.
    assign osc_run = state != st_down;
    assign sep_run = state != st_down;
    assign core_clk_en = state == st_run || state == st_init;
    assign core_rst = state == st_init;
    assign low_power = state == st_down;

    // Output register: the reset bit is a level and holds as written.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            digital_output_reg <= `FPRS_DOR_RST;
        end else if (reg_wr && reg_addr == `FPRS_A_DOR) begin
            digital_output_reg <= reg_wdata;
        end
    end

    // Rate register reset bit lasts one cycle only.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dsr_rst <= 1'b0;
        end else begin
            dsr_rst <= reg_wr && reg_addr == `FPRS_A_DSR &&
                reg_wdata[`FPRS_DSR_RST_BIT];
        end
    end

    // Low-power request bits; a new request wins over the clear on exit.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dsr_lp <= 1'b0;
        end else if (lp_wr) begin
            dsr_lp <= 1'b1;
        end else if (leave_down) begin
            dsr_lp <= 1'b0;
        end
    end

    // The mode bit is also dropped on exit, otherwise the OR would send
    // the device straight back down after every wake-up.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_lp <= 1'b0;
        end else if (mode_valid) begin
            mode_lp <= mode_manual_lp;
        end else if (leave_down) begin
            mode_lp <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            auto_lp_en <= 1'b0;
        end else if (mode_valid) begin
            auto_lp_en <= mode_auto_lp;
        end
    end

    // Data rate follows whichever of the two rate registers was last written.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            data_rate <= `FPRS_RATE_RST;
            precomp_sel <= `FPRS_PRECOMP_RST;
            ccr_rate <= `FPRS_RATE_RST;
        end else if (reg_wr && reg_addr == `FPRS_A_DSR) begin
            data_rate <= reg_wdata[1:0];
            precomp_sel <= reg_wdata[4:2];
        end else if (reg_wr && reg_addr == `FPRS_A_CCR) begin
            data_rate <= reg_wdata[1:0];
            ccr_rate <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lock_flag <= 1'b0;
        end else if (lock_valid) begin
            lock_flag <= lock_val;
        end
    end

    // Settings that the lock protects across a software reset.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || (soft_req && !lock_flag)) begin
            fifo_en <= 1'b0;
            fifo_level_threshold <= `FPRS_FIFO_LEVEL_THRESHOLD_RST;
            precomp_start_track <= `FPRS_PRECOMP_START_TRACK_RST;
        end else if (cfg_valid) begin
            fifo_en <= cfg_fifo_en;
            fifo_level_threshold <= cfg_fifo_level_threshold;
            precomp_start_track <= cfg_precomp_start_track;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || (soft_req && !lock_flag)) begin
            write_fifo_setting <= 1'b0;
            read_fifo_setting <= 1'b0;
            burst_setting <= 1'b0;
        end else if (mode_valid) begin
            write_fifo_setting <= mode_wfifo;
            read_fifo_setting <= mode_rfifo;
            burst_setting <= mode_burst;
        end
    end

    // Seek and polling options are never protected by the lock.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || soft_req) begin
            implied_seek <= 1'b0;
            poll_en <= 1'b1;
        end else if (cfg_valid) begin
            implied_seek <= cfg_implied_seek;
            poll_en <= cfg_poll_en;
        end
    end

    // Status value: all zero during initialisation, request flag held low
    // while powered down or stabilising.
    always_comb begin
        msr_val = msr_core;
        unique case (state)
            st_init: msr_val = `FPRS_MSR_INIT;
            st_run: msr_val = msr_core;
            st_down, st_wake: begin
                msr_val[`FPRS_MSR_RQM_BIT] = 1'b0;
            end
        endcase
    end

    // Data register strobes reach the core only while it runs; an access
    // in power-down only wakes the device.
    assign data_rd = reg_rd && reg_addr == `FPRS_A_DATA && state == st_run;
    assign data_wr = reg_wr && reg_addr == `FPRS_A_DATA && state == st_run;
    assign data_wdata = reg_wdata;

    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            `FPRS_A_STAT: rd_mux = {4'h0, lock_flag, auto_lp_en, state};
            `FPRS_A_DOR: rd_mux = digital_output_reg;
            `FPRS_A_MSR: rd_mux = msr_val;
            `FPRS_A_DATA: rd_mux = data_rd ? data_rdata : 8'h00;
            `FPRS_A_CCR: rd_mux = {6'h00, ccr_rate};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    localparam int INIT_MAX = 625;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_msr_read;
        reg_rd && reg_addr == `FPRS_A_MSR;
    endsequence
    sequence s_soft_go;
        state == st_init && !soft_req && !init_t.run && !init_t.done;
    endsequence

    a_down_no_rqm: assert property (
        state == st_down ##0 s_msr_read |=> !reg_rdata[7])
        else $error("request flag read high in power-down");
    a_lp_stops_osc: assert property (
        $rose(low_power) |-> !osc_run && !sep_run)
        else $error("oscillator runs in low power");
    a_core_halted: assert property (
        !osc_run || state == st_wake |-> !core_clk_en)
        else $error("core enabled without stable oscillator");
    a_soft_wakes: assert property (
        state == st_down && soft_req |=> state == st_init && osc_run)
        else $error("software reset did not wake");
    a_access_wakes: assert property (
        state == st_down && !soft_req && !cfg_valid ##0 s_msr_read
        |=> state == st_wake ##0 $stable(fifo_en))
        else $error("status read did not wake");
    a_wake_rqm_low: assert property (
        state == st_wake ##0 s_msr_read |=> reg_rdata[7] == 1'b0)
        else $error("request flag high while stabilising");
    a_stab_resume: assert property (
        state == st_wake && stab_t.done && !soft_req |=> state == st_run)
        else $error("no resume after stabilisation");
    a_dsr_lp_now: assert property (
        state == st_run && lp_wr && !soft_req |=> state == st_down)
        else $error("manual low power not immediate");
    a_lp_bit_clear: assert property (
        leave_down && !lp_wr |=> !dsr_lp)
        else $error("low-power bit not cleared on exit");
    a_dsr_rst_self: assert property (
        dsr_rst && !(reg_wr && reg_addr == `FPRS_A_DSR) |=> !dsr_rst)
        else $error("rate register reset bit stuck");
    a_lock_keeps: assert property (
        soft_req && lock_flag && !cfg_valid && !mode_valid
        |=> $stable(fifo_level_threshold) && $stable(burst_setting))
        else $error("locked setting lost in reset");
    a_init_bound: assert property (
        s_soft_go ##1 !soft_req [*1]
        |-> ##[0:INIT_MAX] (state == st_run || soft_req))
        else $error("status not ready within bound");
    a_auto_enter: assert property (
        state == st_run && auto_t.done && !soft_req |=> state == st_down)
        else $error("automatic low power not entered");
endmodule // fprs_sequencer
`default_nettype wire

// [rtl/fprs_cfg.svh]
`ifndef FPRS_CFG_SVH
`define FPRS_CFG_SVH
`define FPRS_CLK_NS 4
`define FPRS_MS_NS 1000000
`define FPRS_INIT_NS 2500
`define FPRS_INIT_CYC (`FPRS_INIT_NS / `FPRS_CLK_NS)
`define FPRS_AUTO_LP_MS 500
`define FPRS_STAB_MS 2
`define FPRS_A_STAT 3'h0
`define FPRS_A_DOR 3'h2
`define FPRS_A_MSR 3'h4
`define FPRS_A_DSR 3'h4
`define FPRS_A_DATA 3'h5
`define FPRS_A_CCR 3'h7
`define FPRS_DOR_RST 8'h04
`define FPRS_DOR_NRST_BIT 2
`define FPRS_DSR_LP_BIT 6
`define FPRS_DSR_RST_BIT 7
`define FPRS_MSR_RQM_BIT 7
`define FPRS_MSR_INIT 8'h00
`define FPRS_RATE_RST 2'h0
`define FPRS_PRECOMP_RST 3'h0
`define FPRS_FIFO_LEVEL_THRESHOLD_RST 4'h0
`define FPRS_PRECOMP_START_TRACK_RST 8'h00
`endif

// [rtl/fprs_pkg.sv]
`default_nettype none
package fprs_pkg;
    typedef logic [15:0] fprs_cnt_t;
    typedef enum logic [1:0] {st_init, st_run, st_down, st_wake} fprs_state_e;
endpackage
`default_nettype wire

// [rtl/fprs_tmr_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface fprs_tmr_if;
    import fprs_pkg::*;
    logic start;
    logic stop;
    logic tick;
    fprs_cnt_t limit;
    logic run;
    logic done;
    modport timer(input start, stop, tick, limit, output run, done);
    modport user(output start, stop, tick, limit, input run, done);
endinterface
`default_nettype wire

// [rtl/fprs_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module fprs_timer
    import fprs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Control
    fprs_tmr_if.timer t
);
    fprs_cnt_t cnt;

    // A limit of zero wraps and only expires after 65536 ticks, so callers keep it at one or more.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || t.stop) begin
            cnt <= '0;
            t.run <= 1'b0;
            t.done <= 1'b0;
        end else begin
            t.done <= 1'b0;
            if (t.start) begin
                cnt <= t.limit;
                t.run <= 1'b1;
            end else if (t.run && t.tick) begin
                if (cnt == 16'h0001) begin
                    t.run <= 1'b0;
                    t.done <= 1'b1;
                end
                cnt <= cnt - 16'h0001;
            end
        end
    end
endmodule // fprs_timer
`default_nettype wire

// [tb/fprs_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fprs_core_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Sequencer side
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    input wire logic core_clk_en,
    input wire logic core_rst,
    output logic [7:0] data_rdata,
    output logic [7:0] msr_core,
    output logic core_idle,
    // Bench control
    input wire logic idle_req
);
    logic [7:0] last_wr;

    // A gated core only takes a byte while its clock is enabled.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || core_rst) begin
            last_wr <= 8'h00;
        end else if (core_clk_en && data_wr) begin
            last_wr <= data_wdata;
        end
    end

    // Reads return the inverse so a lost write cannot pass unseen.
    assign data_rdata = ~last_wr;
    assign msr_core = 8'h80;
    assign core_idle = idle_req;
endmodule // fprs_core_model
`default_nettype wire

// [tb/test_fdc_power_reset_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fprs_cfg.svh"
`define CHK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("MISMATCH %s expected %h seen %h", nm, e, g); \
    end \
end
module test_fdc_power_reset_sequencer;
    logic ref_clk = 1'b0;
    logic sys_rst, reg_wr, reg_rd, rd_pend, idle_req;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, data_wdata, data_rdata, msr_core;
    logic data_rd, data_wr, core_idle, cfg_valid, cfg_fifo_en;
    logic [3:0] cfg_fifo_level_threshold, fifo_level_threshold;
    logic [7:0] cfg_precomp_start_track, digital_output_reg, precomp_start_track;
    logic cfg_implied_seek, cfg_poll_en, mode_valid, mode_manual_lp;
    logic mode_auto_lp, mode_wfifo, mode_rfifo, mode_burst, lock_valid;
    logic lock_val, osc_run, sep_run, core_clk_en, core_rst, low_power;
    logic [1:0] data_rate;
    logic [2:0] precomp_sel;
    logic fifo_en, implied_seek, poll_en, write_fifo_setting;
    logic read_fifo_setting, burst_setting, lock_flag;
    logic [7:0] exp_q[$], msk_q[$];
    logic [7:0] e, m;
    logic [15:0] set_exp;
    logic [31:0] r;
    int fail_count = 0, comparisons = 0, cycles = 0;
    wire [15:0] set_now = {fifo_en, fifo_level_threshold,
        precomp_start_track, write_fifo_setting, read_fifo_setting,
        burst_setting};
    wire [4:0] pwr = {low_power, osc_run, sep_run, core_clk_en, core_rst};
    wire [24:0] dflt = {set_now[15:3], implied_seek, poll_en, lock_flag,
        digital_output_reg, low_power};

    fprs_sequencer #(.MS_CYCLES(10), .STAB_MS(3), .AUTO_LP_MS(3)) dut (
        .ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .data_rd, .data_wr, .data_wdata, .data_rdata,
        .msr_core, .core_idle, .cfg_valid, .cfg_fifo_en, .cfg_fifo_level_threshold,
        .cfg_precomp_start_track, .cfg_implied_seek, .cfg_poll_en, .mode_valid,
        .mode_manual_lp, .mode_auto_lp, .mode_wfifo, .mode_rfifo,
        .mode_burst, .lock_valid, .lock_val, .osc_run, .sep_run,
        .core_clk_en, .core_rst, .low_power, .digital_output_reg,
        .data_rate, .precomp_sel, .fifo_en, .fifo_level_threshold,
        .precomp_start_track, .implied_seek, .poll_en,
        .write_fifo_setting, .read_fifo_setting, .burst_setting,
        .lock_flag);

    fprs_core_model core (
        .ref_clk, .sys_rst, .data_rd, .data_wr, .data_wdata,
        .core_clk_en, .core_rst, .data_rdata, .msr_core, .core_idle,
        .idle_req);

    // The reference clock never stops, so it outlasts every low power entry.
    always #2 ref_clk = ~ref_clk;

    task automatic test_done;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // The whole sequence needs about 3000 cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 9000) begin
            fail_count++;
            test_done();
        end
    end

    // Read data stand only in the cycle after the strobe.
    always @(posedge ref_clk) rd_pend <= reg_rd;
    always @(negedge ref_clk) begin
        if (rd_pend && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            `CHK("reg_rdata", e & m, reg_rdata & m)
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] x,
                      input logic [7:0] k = 8'hff);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(x);
        msk_q.push_back(k);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic wait_lp(input logic v, input int n);
        for (int i = 0; i < n && low_power !== v; i++) @(posedge ref_clk);
        #1;
        `CHK("low_power", v, low_power)
    endtask

    task automatic hw_reset;
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        cyc(12);
        sys_rst <= 1'b0;
        #1;
        `CHK("defaults", 25'h0000408, dflt)
    endtask

    task automatic pulse_mode(input logic man, input logic auto_lp);
        @(posedge ref_clk);
        mode_valid <= 1'b1;
        mode_manual_lp <= man;
        mode_auto_lp <= auto_lp;
        @(posedge ref_clk);
        mode_valid <= 1'b0;
        mode_manual_lp <= 1'b0;
    endtask

    task automatic pulse_lock(input logic v);
        @(posedge ref_clk);
        lock_valid <= 1'b1;
        lock_val <= v;
        @(posedge ref_clk);
        lock_valid <= 1'b0;
    endtask

    initial begin
        {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, idle_req} = 15'h4000;
        {cfg_valid, cfg_fifo_en, cfg_fifo_level_threshold, cfg_precomp_start_track} = 14'h0;
        {cfg_implied_seek, cfg_poll_en, mode_valid, mode_manual_lp} = 4'h0;
        {mode_auto_lp, mode_wfifo, mode_rfifo, mode_burst} = 4'h0;
        {lock_valid, lock_val} = 2'h0;
        void'($urandom(32'hf681e49d));
        hw_reset();
        // The core model keeps no drive timing, so nothing is reissued.
        rd(`FPRS_A_MSR, 8'h00);
        wr(`FPRS_A_CCR, 8'h02);
        rd(`FPRS_A_CCR, 8'h02);
        wr(`FPRS_A_DOR, 8'h0c);
        rd(`FPRS_A_DOR, 8'h0c);
        for (int a = 1; a < 7; a += 2) rd(3'(a + a / 5), 8'h00);
        cyc(560);
        rd(`FPRS_A_MSR, 8'h00);
        cyc(50);
        rd(`FPRS_A_MSR, 8'h80);
        rd(`FPRS_A_STAT, 8'h01);
        r = $urandom;
        set_exp = {1'b1, r[11:0], r[12], r[13], r[14]};
        @(posedge ref_clk);
        {cfg_valid, cfg_fifo_en, cfg_implied_seek, cfg_poll_en} <= 4'he;
        {cfg_fifo_level_threshold, cfg_precomp_start_track} <= r[11:0];
        {mode_valid, mode_wfifo, mode_rfifo, mode_burst} <=
            {1'b1, r[12], r[13], r[14]};
        @(posedge ref_clk);
        {cfg_valid, mode_valid} <= 2'b00;
        pulse_lock(1'b1);
        wr(`FPRS_A_DATA, 8'h3c);
        rd(`FPRS_A_DATA, 8'hc3);
        // Motor and drive selects are switched off before sleeping.
        wr(`FPRS_A_DOR, 8'h04);
        wr(`FPRS_A_DSR, 8'h41);
        #1;
        `CHK("pwr_down", 5'b10000, pwr)
        rd(`FPRS_A_STAT, 8'h0a);
        rd(`FPRS_A_DOR, 8'h04);
        rd(`FPRS_A_CCR, 8'h02);
        `CHK("rate", 5'h01, {precomp_sel, data_rate})
        rd(`FPRS_A_MSR, 8'h00, 8'h80);
        rd(`FPRS_A_STAT, 8'h0b);
        rd(`FPRS_A_MSR, 8'h00, 8'h80);
        cyc(40);
        rd(`FPRS_A_MSR, 8'h80);
        `CHK("settings", set_exp, set_now)
        cyc(40);
        `CHK("pwr_run", 5'b01110, pwr)
        pulse_mode(1'b1, 1'b0);
        wait_lp(1'b1, 3);
        wr(`FPRS_A_DATA, 8'h11);
        cyc(80);
        rd(`FPRS_A_STAT, 8'h09);
        rd(`FPRS_A_DATA, 8'hc3);
        wr(`FPRS_A_DSR, 8'h01);
        rd(`FPRS_A_STAT, 8'h09);
        pulse_mode(1'b0, 1'b1);
        idle_req <= 1'b1;
        cyc(15);
        `CHK("low_power", 1'b0, low_power)
        wait_lp(1'b1, 20);
        rd(`FPRS_A_STAT, 8'h0e);
        rd(`FPRS_A_MSR, 8'h00, 8'h80);
        cyc(5);
        wait_lp(1'b1, 80);
        idle_req <= 1'b0;
        wr(`FPRS_A_DSR, 8'h80);
        @(posedge ref_clk);
        #1;
        `CHK("pwr_init", 5'b01111, pwr)
        rd(`FPRS_A_STAT, 8'h0c);
        rd(`FPRS_A_MSR, 8'h00);
        cyc(640);
        rd(`FPRS_A_MSR, 8'h80);
        `CHK("settings", set_exp, set_now)
        pulse_lock(1'b0);
        wr(`FPRS_A_DOR, 8'h00);
        cyc(700);
        rd(`FPRS_A_STAT, 8'h04);
        rd(`FPRS_A_DOR, 8'h00);
        wr(`FPRS_A_DOR, 8'h04);
        cyc(640);
        rd(`FPRS_A_MSR, 8'h80);
        `CHK("no_lock", 13'h0, set_now[15:3])
        @(posedge ref_clk);
        {cfg_valid, mode_valid} <= 2'b11;
        @(posedge ref_clk);
        {cfg_valid, mode_valid} <= 2'b00;
        pulse_lock(1'b1);
        hw_reset();
        cyc(4);
        `CHK("queue", 0, exp_q.size())
        test_done();
    end
endmodule // test_fdc_power_reset_sequencer
`default_nettype wire
